// ===== rtl/sbcmc_top.sv
// mode controller, serial slave port and watchdog/status register
`timescale 1ns/1ps
module sbcmc_top
    import sbcmc_pkg::*;
#(
    parameter int SHORT_RST_CYCLES = SHORT_RST_CYC,
    parameter int LONG_RST_CYCLES  = LONG_RST_CYC
) (
    // clock and reset
    input  logic       CLOCK,
    input  logic       RST,
    // serial port
    input  logic       SCK,
    input  logic       SERIAL_SELECT_N,
    input  logic       SERIAL_IN_PIN,
    output logic       SERIAL_OUT_PIN,
    output logic       SERIAL_OUT_OE,
    // asynchronous events and levels
    input  logic       CAN_WAKE,
    input  logic       LIN_WAKE,
    input  logic       LOCAL_WAKE,
    input  logic       OTP_ACT,
    input  logic       OTP_REL,
    input  logic       WDOG_DISABLE_PIN,
    input  logic       MAIN_REG_UV_FLAG,
    input  logic       CAN_REG_UV_FLAG,
    input  logic       WAKE_IN1_LEVEL,
    input  logic       WAKE_IN2_LEVEL,
    // same-clock status from neighbouring logic
    input  logic       IRQ_OUT_N,
    input  logic       WAKE_PENDING,
    input  logic [2:0] WAKE_SRC_EN,
    input  logic       CAN_STANDBY_SEL,
    input  logic       LIN_STANDBY_SEL,
    input  logic       LONG_RESET_SEL,
    // control outputs
    output logic       RESET_OUT_N,
    output logic       MAIN_REG_EN,
    output logic       CAN_REG_EN,
    output logic       CAN_XCVR_ACTIVE,
    output logic       CAN_XCVR_LOWPWR,
    output logic       LIN_XCVR_ACTIVE,
    output logic       LIN_XCVR_LOWPWR,
    output logic       BUS_HIGH_Z,
    output logic       FALLBACK_DRIVE_OE,
    output logic [1:0] WDOG_MODE,
    output logic [2:0] WDOG_PERIOD_SEL,
    output logic [1:0] OP_MODE_STATE
);

    if (SHORT_RST_CYCLES < 1 || SHORT_RST_CYCLES >= (1 << RST_CNT_W))
    begin : g_bad_short
        $error("short reset count out of range");
    end
    if (LONG_RST_CYCLES < 1 || LONG_RST_CYCLES >= (1 << RST_CNT_W))
    begin : g_bad_long
        $error("long reset count out of range");
    end

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] sync1_reg;
    logic [PIN_COUNT-1:0] sync2_reg;
    logic [PIN_COUNT-1:0] sync3_reg;
    logic [PIN_COUNT-1:0] filt_reg;
    sbcmc_pins_t          pins;
    logic                 sck_d_reg;
    logic                 sel_d_reg;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 sel_rise;
    logic [4:0]           bit_cnt_reg;
    logic [15:0]          rx_reg;
    logic [3:0]           hdr_reg;
    logic [11:0]          rd_data;
    logic                 wr_strobe;
    logic [2:0]           wr_addr;
    logic                 wmc_reg;
    logic [2:0]           nwp_reg;
    logic [11:0]          mode_ctrl_reg;
    logic [11:0]          irq_ctrl_reg;
    logic [11:0]          irq_status_reg;
    sbcmc_state_t         state_reg;
    logic                 rst_active_reg;
    logic [RST_CNT_W-1:0] rst_cnt_reg;
    logic                 mc_wr;
    sbcmc_mc_t            new_mc;
    sbcmc_mc_t            cur_mc;
    logic                 sleep_ok;
    logic                 sleep_reject;
    logic                 wake_exit;
    logic                 ot_exit;
    logic                 op_active;
    logic                 sysrst_start;
    logic                 rst_long;

    assign pin_raw = {SCK, SERIAL_SELECT_N, SERIAL_IN_PIN, CAN_WAKE,
                      LIN_WAKE, LOCAL_WAKE, OTP_ACT, OTP_REL,
                      WDOG_DISABLE_PIN, MAIN_REG_UV_FLAG, CAN_REG_UV_FLAG,
                      WAKE_IN1_LEVEL, WAKE_IN2_LEVEL};

    // three-stage sync; a level is taken once stages two and three agree
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                sync1_reg[i] <= PIN_RST[i];
                sync2_reg[i] <= PIN_RST[i];
                sync3_reg[i] <= PIN_RST[i];
                filt_reg[i]  <= PIN_RST[i];
            end else begin
                sync1_reg[i] <= pin_raw[i];
                sync2_reg[i] <= sync1_reg[i];
                sync3_reg[i] <= sync2_reg[i];
                if (sync2_reg[i] == sync3_reg[i]) begin
                    filt_reg[i] <= sync2_reg[i];
                end
            end
        end
    end

    assign pins = filt_reg;

    // serial clock idles low, so no edge is seen between words
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sck_d_reg <= 1'b0;
            sel_d_reg <= 1'b1;
        end else begin
            sck_d_reg <= pins.sck;
            sel_d_reg <= pins.sel_n;
        end
    end

    assign sck_rise = pins.sck & ~sck_d_reg;
    assign sck_fall = ~pins.sck & sck_d_reg;
    assign sel_rise = pins.sel_n & ~sel_d_reg;

    // shift engine
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            bit_cnt_reg    <= 5'h00;
            rx_reg         <= 16'h0000;
            hdr_reg        <= 4'h0;
            SERIAL_OUT_PIN <= 1'b0;
            SERIAL_OUT_OE  <= 1'b0;
        end else begin
            SERIAL_OUT_OE <= ~pins.sel_n;
            if (pins.sel_n) begin
                bit_cnt_reg    <= 5'h00;
                SERIAL_OUT_PIN <= 1'b0;
            end else begin
                if (sck_fall && bit_cnt_reg < 5'(WORD_BITS)) begin
                    rx_reg      <= {rx_reg[14:0], pins.serial_in_pin};
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == 5'(HDR_BITS - 1)) begin
                        hdr_reg <= {rx_reg[2:0], pins.serial_in_pin};
                    end
                end
                // header time returns zeros, then the addressed contents
                if (sck_rise) begin
                    if (bit_cnt_reg >= 5'(HDR_BITS) &&
                        bit_cnt_reg < 5'(WORD_BITS)) begin
                        SERIAL_OUT_PIN <= rd_data[4'(5'd15 - bit_cnt_reg)];
                    end else begin
                        SERIAL_OUT_PIN <= 1'b0;
                    end
                end
            end
        end
    end

    // read-back word, bits 7 to 3 of the watchdog/status word are live status
    assign cur_mc = sbcmc_mc_t'(mode_ctrl_reg[MC_HI:MC_LO]);
    always_comb begin
        unique case (hdr_reg[3:1])
            ADDR_WDOG_STATUS: rd_data = {wmc_reg, nwp_reg, pins.wdog_off,
                                         pins.main_uv, pins.can_uv,
                                         pins.wake1, pins.wake2,
                                         3'h0};
            ADDR_MODE_CTRL:   rd_data = mode_ctrl_reg;
            ADDR_IRQ_CTRL:    rd_data = irq_ctrl_reg;
            ADDR_IRQ_STATUS:  rd_data = irq_status_reg;
            default:          rd_data = 12'h000;
        endcase
    end

    // commit only whole words with the read-only flag clear
    assign wr_strobe = sel_rise && bit_cnt_reg == 5'(WORD_BITS)
                       && !rx_reg[RO_POS];
    assign wr_addr   = rx_reg[ADDR_HI:ADDR_LO];
    assign new_mc    = sbcmc_mc_t'(rx_reg[MC_HI:MC_LO]);

    assign op_active    = state_reg == ST_STANDBY || state_reg == ST_NORMAL;
    assign mc_wr        = wr_strobe && wr_addr == ADDR_MODE_CTRL;
    assign sleep_ok     = IRQ_OUT_N && !WAKE_PENDING
                          && |WAKE_SRC_EN;
    assign sleep_reject = op_active && !pins.otp_act && mc_wr
                          && new_mc == MC_SLEEP && !sleep_ok;
    assign wake_exit    = state_reg == ST_SLEEP &&
                          (pins.can_wake | pins.lin_wake | pins.local_wake);
    assign ot_exit      = state_reg == ST_OVERTEMP && pins.otp_rel;
    assign sysrst_start = sleep_reject | wake_exit | ot_exit;
    assign rst_long     = !sleep_reject && LONG_RESET_SEL;

    // operating mode and mode control register
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_reg     <= ST_STANDBY;
            mode_ctrl_reg <= MODE_CTRL_RST;
        end else begin
            unique case (state_reg)
                ST_STANDBY, ST_NORMAL: begin
                    if (pins.otp_act) begin
                        state_reg              <= ST_OVERTEMP;
                        mode_ctrl_reg[LHC_POS] <= 1'b1;
                    end else if (mc_wr) begin
                        mode_ctrl_reg[9:0] <= rx_reg[9:0];
                        unique case (new_mc)
                            MC_SLEEP: begin
                                if (sleep_ok) begin
                                    state_reg <= ST_SLEEP;
                                    mode_ctrl_reg[MC_HI:MC_LO] <= MC_SLEEP;
                                end else begin
                                    state_reg <= ST_STANDBY;
                                    mode_ctrl_reg[MC_HI:MC_LO] <= MC_STANDBY;
                                end
                            end
                            MC_NORMAL_V2, MC_NORMAL_ON: begin
                                state_reg <= ST_NORMAL;
                                mode_ctrl_reg[MC_HI:MC_LO] <= new_mc;
                            end
                            MC_STANDBY: begin
                                state_reg <= ST_STANDBY;
                                mode_ctrl_reg[MC_HI:MC_LO] <= MC_STANDBY;
                            end
                        endcase
                    end
                end
                ST_SLEEP: begin
                    if (wake_exit) begin
                        state_reg <= ST_STANDBY;
                        mode_ctrl_reg[MC_HI:MC_LO] <= MC_STANDBY;
                    end
                end
                ST_OVERTEMP: begin
                    if (ot_exit) begin
                        state_reg <= ST_STANDBY;
                        mode_ctrl_reg[MC_HI:MC_LO] <= MC_STANDBY;
                    end
                end
            endcase
        end
    end

    // watchdog/status writable fields; period returns to default on reset
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wmc_reg <= WMC_RST;
            nwp_reg <= NWP_RST;
        end else if (sysrst_start) begin
            nwp_reg <= NWP_RST;
        end else if (wr_strobe && wr_addr == ADDR_WDOG_STATUS) begin
            wmc_reg <= rx_reg[WMC_POS];
            nwp_reg <= rx_reg[NWP_HI:NWP_LO];
        end
    end

    // interrupt registers are plain storage here
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_ctrl_reg   <= IRQ_CTRL_RST;
            irq_status_reg <= IRQ_STAT_RST;
        end else if (wr_strobe) begin
            if (wr_addr == ADDR_IRQ_CTRL) begin
                irq_ctrl_reg <= rx_reg[DATA_BITS-1:0];
            end
            if (wr_addr == ADDR_IRQ_STATUS) begin
                irq_status_reg <= rx_reg[DATA_BITS-1:0];
            end
        end
    end

    // system reset pulse; power-up uses the short width
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rst_active_reg <= 1'b1;
            rst_cnt_reg    <= RST_CNT_W'(SHORT_RST_CYCLES - 1);
        end else if (sysrst_start) begin
            rst_active_reg <= 1'b1;
            rst_cnt_reg    <= rst_long ? RST_CNT_W'(LONG_RST_CYCLES - 1)
                                       : RST_CNT_W'(SHORT_RST_CYCLES - 1);
        end else if (rst_active_reg) begin
            if (rst_cnt_reg == '0) begin
                rst_active_reg <= 1'b0;
            end else begin
                rst_cnt_reg <= rst_cnt_reg - RST_CNT_W'(1);
            end
        end
    end

    // registered outputs, one cycle behind state
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RESET_OUT_N       <= 1'b0;
            MAIN_REG_EN       <= 1'b0;
            CAN_REG_EN        <= 1'b0;
            CAN_XCVR_ACTIVE   <= 1'b0;
            CAN_XCVR_LOWPWR   <= 1'b0;
            LIN_XCVR_ACTIVE   <= 1'b0;
            LIN_XCVR_LOWPWR   <= 1'b0;
            BUS_HIGH_Z        <= 1'b0;
            FALLBACK_DRIVE_OE <= 1'b0;
            WDOG_MODE         <= WD_OFF;
            WDOG_PERIOD_SEL   <= NWP_RST;
            OP_MODE_STATE     <= ST_STANDBY;
        end else begin
            RESET_OUT_N     <= !rst_active_reg && op_active;
            MAIN_REG_EN     <= op_active;
            CAN_REG_EN      <= state_reg == ST_NORMAL
                               && cur_mc == MC_NORMAL_ON;
            CAN_XCVR_ACTIVE <= state_reg == ST_NORMAL && !CAN_STANDBY_SEL;
            CAN_XCVR_LOWPWR <= state_reg != ST_OVERTEMP
                               && CAN_STANDBY_SEL;
            LIN_XCVR_ACTIVE <= state_reg == ST_NORMAL && !LIN_STANDBY_SEL;
            LIN_XCVR_LOWPWR <= state_reg != ST_OVERTEMP
                               && LIN_STANDBY_SEL;
            BUS_HIGH_Z      <= state_reg == ST_OVERTEMP;
            FALLBACK_DRIVE_OE <= mode_ctrl_reg[LHC_POS];
            WDOG_PERIOD_SEL <= nwp_reg;
            OP_MODE_STATE   <= state_reg;
            // disable pin overrides everything
            if (!op_active || pins.wdog_off) begin
                WDOG_MODE <= WD_OFF;
            end else if (state_reg == ST_NORMAL) begin
                WDOG_MODE <= wmc_reg ? WD_TIMEOUT : WD_WINDOW;
            end else begin
                WDOG_MODE <= wmc_reg ? WD_OFF : WD_TIMEOUT;
            end
        end
    end

endmodule // sbcmc_top

// ===== rtl/sbcmc_pkg.sv
// constants, types and field layout for the mode controller and serial port
// Operation
// - host writes mode field 01 from Standby or Normal to request Sleep
// - Sleep needs no pending interrupt or wake and one enabled wake source
// - a refused Sleep request gives a short system reset of at least 3.6 ms
// - Sleep: both regulators off, watchdog stopped, reset output held low
// - Sleep: transceiver off if standby select 0, low-power wake if 1
// - wake in Sleep: go Standby, system reset, mode field 00, main regulator on
// - overtemperature in Normal or Standby: Overtemp, regulators off, bus high-Z
// - entering Overtemp drives reset low and sets limp control bit
// - release indication leaves Overtemp to Standby with a system reset
// - serial port full duplex: status shifts out while control shifts in
// - header bit 12: 0 writes register, 1 reads without altering
// - select is active low; data output floats while select is high
// - sample on falling serial clock edge, shift out on rising edge
// - header bits 15 to 13 give address, bit 12 read-only flag
// - addresses 000 to 011 decode four registers; bits 11 to 0 data
// - watchdog mode bit 11 picks Window/Timeout or Timeout/Off behaviour
// - period field 10:8 selects 8 to 4096 ms
// - any reset returns the period field to code 100
// - bit 7 reads 1 while watchdog disable pin is high
// - bits 6 and 5 report main and CAN regulator undervoltage
// - bits 4 and 3 show live local wake input levels
// - mode field: 00 Standby, 01 Sleep, 10 Normal CAN off, 11 Normal CAN on
package sbcmc_pkg;

    // timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int SHORT_RST_NS    = 3600000;
    localparam int LONG_RST_NS     = 20000000;
    localparam int SHORT_RST_CYC   =
        (SHORT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_RST_CYC    =
        (LONG_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W       = 24;

    // serial word layout
    localparam int WORD_BITS       = 16;
    localparam int HDR_BITS        = 4;
    localparam int ADDR_HI         = 15;
    localparam int ADDR_LO         = 13;
    localparam int RO_POS          = 12;
    localparam int DATA_BITS       = 12;

    // register addresses
    localparam logic [2:0] ADDR_WDOG_STATUS = 3'h0;
    localparam logic [2:0] ADDR_MODE_CTRL   = 3'h1;
    localparam logic [2:0] ADDR_IRQ_CTRL    = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h3;

    // watchdog/status fields
    localparam int WMC_POS         = 11;
    localparam int NWP_HI          = 10;
    localparam int NWP_LO          = 8;
    localparam logic       WMC_RST = 1'b0;
    localparam logic [2:0] NWP_RST = 3'h4;

    // mode control fields
    localparam int MC_HI           = 11;
    localparam int MC_LO           = 10;
    localparam int LHC_POS         = 8;
    localparam logic [11:0] MODE_CTRL_RST = 12'h200;
    localparam logic [11:0] IRQ_CTRL_RST  = 12'h000;
    localparam logic [11:0] IRQ_STAT_RST  = 12'h000;

    typedef enum logic [1:0] {
        MC_STANDBY   = 2'b00,
        MC_SLEEP     = 2'b01,
        MC_NORMAL_V2 = 2'b10,
        MC_NORMAL_ON = 2'b11
    } sbcmc_mc_t;

    typedef enum logic [1:0] {
        ST_STANDBY  = 2'b00,
        ST_NORMAL   = 2'b01,
        ST_SLEEP    = 2'b10,
        ST_OVERTEMP = 2'b11
    } sbcmc_state_t;

    typedef enum logic [1:0] {
        WD_OFF     = 2'b00,
        WD_TIMEOUT = 2'b01,
        WD_WINDOW  = 2'b10
    } sbcmc_wd_t;

    // pins from outside the clock domain, msb first
    typedef struct packed {
        logic sck;
        logic sel_n;
        logic serial_in_pin;
        logic can_wake;
        logic lin_wake;
        logic local_wake;
        logic otp_act;
        logic otp_rel;
        logic wdog_off;
        logic main_uv;
        logic can_uv;
        logic wake1;
        logic wake2;
    } sbcmc_pins_t;

    localparam int PIN_COUNT = 13;
    localparam logic [12:0] PIN_RST = 13'h0800;

endpackage

// ===== verif/sbcmc_checker.sv
// concurrent checks on the mode controller and serial port pins
`timescale 1ns/1ps
module sbcmc_checker #(
    parameter int SHORT_RST_CYCLES = 20
) (
    // clock and reset
    input logic       CLOCK,
    input logic       RST,
    // pins in
    input logic       SERIAL_SELECT_N,
    input logic       CAN_WAKE,
    input logic       OTP_ACT,
    input logic       OTP_REL,
    input logic       CAN_STANDBY_SEL,
    // pins out
    input logic       SERIAL_OUT_OE,
    input logic       RESET_OUT_N,
    input logic       MAIN_REG_EN,
    input logic       CAN_REG_EN,
    input logic       CAN_XCVR_ACTIVE,
    input logic       CAN_XCVR_LOWPWR,
    input logic       BUS_HIGH_Z,
    input logic       FALLBACK_DRIVE_OE,
    input logic [1:0] WDOG_MODE,
    input logic [2:0] WDOG_PERIOD_SEL,
    input logic [1:0] OP_MODE_STATE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // length of the current reset-output low phase
    int unsigned low_cnt;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST || RESET_OUT_N) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end

    sequence sleep_steady;
        OP_MODE_STATE == 2'b10 && $past(OP_MODE_STATE) == 2'b10
            && $stable(CAN_STANDBY_SEL);
    endsequence
    sequence ot_left;
        OP_MODE_STATE == 2'b11 ##1 OP_MODE_STATE != 2'b11;
    endsequence

    // select pin passes a synchroniser, so allow 8 samples
    AST_OE_RELEASE: assert property (SERIAL_SELECT_N [*8] |->
        !SERIAL_OUT_OE) else $error("data output driven while deselected");
    AST_SLEEP_OUTS: assert property (OP_MODE_STATE == 2'b10 |->
        !RESET_OUT_N && !MAIN_REG_EN && !CAN_REG_EN && WDOG_MODE == 2'b00)
        else $error("sleep outputs wrong");
    AST_SLEEP_XCVR: assert property (sleep_steady |->
        !CAN_XCVR_ACTIVE && CAN_XCVR_LOWPWR == CAN_STANDBY_SEL)
        else $error("sleep transceiver state wrong");
    AST_OT_OUTS: assert property (OP_MODE_STATE == 2'b11 |->
        !RESET_OUT_N && BUS_HIGH_Z && FALLBACK_DRIVE_OE && !MAIN_REG_EN
        && !CAN_REG_EN) else $error("overtemp outputs wrong");
    AST_OT_ENTRY: assert property ($rose(OTP_ACT) &&
        !OP_MODE_STATE[1] |-> ##[1:8] OP_MODE_STATE == 2'b11)
        else $error("overtemp not entered");
    AST_OT_HOLD: assert property ((OP_MODE_STATE == 2'b11 &&
        !OTP_REL) [*6] |=> OP_MODE_STATE == 2'b11)
        else $error("overtemp left without release");
    AST_OT_EXIT: assert property (ot_left |->
        OP_MODE_STATE == 2'b00 && !RESET_OUT_N)
        else $error("overtemp exit without standby reset");
    AST_WAKE_EXIT: assert property (OP_MODE_STATE == 2'b10 &&
        CAN_WAKE |-> ##[1:8] OP_MODE_STATE == 2'b00 && MAIN_REG_EN)
        else $error("wake did not reach standby");
    AST_RST_MIN: assert property ($rose(RESET_OUT_N) |->
        low_cnt >= SHORT_RST_CYCLES) else $error("reset pulse too short");
    AST_NWP_RESET: assert property ($rose(RESET_OUT_N) |->
        WDOG_PERIOD_SEL == 3'h4) else $error("period code not restored");
endmodule // sbcmc_checker

// ===== verif/sbcmc_host.sv
// host serial master model for the slave port
`timescale 1ns/1ps
module sbcmc_host (
    // serial wires
    output logic sck,
    output logic sel_n,
    output logic serial_in_pin,
    input  logic serial_out_pin
);
    initial begin
        sck   = 1'b0;
        sel_n = 1'b1;
        serial_in_pin   = 1'b0;
    end

    // n bits of w msb first, 125 ns bit period; short n aborts a word
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r     = 16'h0000;
        sel_n = 1'b0;
        #62.5;
        for (int i = 15; i > 15 - n; i--) begin
            sck = 1'b1;
            serial_in_pin = w[i];
            #62.5;
            sck = 1'b0;
            r   = {r[14:0], serial_out_pin};
            #62.5;
        end
        // released data line must not keep its last level
        serial_in_pin   = ~serial_in_pin;
        sel_n = 1'b1;
        #62.5;
    endtask
endmodule // sbcmc_host

// ===== verif/tb_sbcmc_top.sv
// self-checking bench for the mode controller and serial port
`timescale 1ns/1ps
module tb_sbcmc_top;
    import sbcmc_pkg::*;
    localparam int SHORT_N = 50;
    localparam int LONG_N  = 200;
    logic clock, rst, sck, sel_n, serial_in_pin, sdo_w, sdo_last, out_pin, out_oe;
    logic can_wake, otp_act, otp_rel, wd_pin, can_uv, wake1, wake2;
    logic irq_n, can_sel, long_sel, rst_n, main_en, can_en, wake_pend;
    logic can_act, can_lp, lin_act, lin_lp, hiz, limp;
    logic [2:0] wake_en, wd_per;
    logic [1:0] wd_mode, op_state;
    logic [15:0] rd;
    int errors, check_count;

    sbcmc_top #(.SHORT_RST_CYCLES(SHORT_N), .LONG_RST_CYCLES(LONG_N)) dut_u (
        .CLOCK(clock), .RST(rst), .SCK(sck), .SERIAL_SELECT_N(sel_n),
        .SERIAL_IN_PIN(serial_in_pin), .SERIAL_OUT_PIN(out_pin),
        .SERIAL_OUT_OE(out_oe), .CAN_WAKE(can_wake), .LIN_WAKE(1'b0),
        .LOCAL_WAKE(1'b0), .OTP_ACT(otp_act), .OTP_REL(otp_rel),
        .WDOG_DISABLE_PIN(wd_pin), .MAIN_REG_UV_FLAG(1'b0),
        .CAN_REG_UV_FLAG(can_uv), .WAKE_IN1_LEVEL(wake1),
        .WAKE_IN2_LEVEL(wake2), .IRQ_OUT_N(irq_n), .WAKE_PENDING(wake_pend),
        .WAKE_SRC_EN(wake_en), .CAN_STANDBY_SEL(can_sel),
        .LIN_STANDBY_SEL(1'b0), .LONG_RESET_SEL(long_sel),
        .RESET_OUT_N(rst_n), .MAIN_REG_EN(main_en), .CAN_REG_EN(can_en),
        .CAN_XCVR_ACTIVE(can_act), .CAN_XCVR_LOWPWR(can_lp),
        .LIN_XCVR_ACTIVE(lin_act), .LIN_XCVR_LOWPWR(lin_lp),
        .BUS_HIGH_Z(hiz), .FALLBACK_DRIVE_OE(limp), .WDOG_MODE(wd_mode),
        .WDOG_PERIOD_SEL(wd_per), .OP_MODE_STATE(op_state));
    sbcmc_host host_u (.sck(sck), .sel_n(sel_n), .serial_in_pin(serial_in_pin), .serial_out_pin(sdo_w));

    // floating output shows the inverse of its last driven level
    always @(posedge clock) if (out_oe) sdo_last <= out_pin;
    assign sdo_w = out_oe ? out_pin : ~sdo_last;

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic test_done();
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        host_u.xfer({a, 1'b0, d}, 16, rd);
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [11:0] e);
        host_u.xfer({a, 1'b1, 12'h000}, 16, rd);
        chk(rd, {4'h0, e});
    endtask
    task automatic settle();
        repeat (10) @(negedge clock);
    endtask
    // bounded wait for the reset output to rise; len counts waited cycles
    task automatic wait_rst(input int n, output int len);
        len = 0;
        while (rst_n !== 1'b1) begin
            @(negedge clock);
            len++;
            if (len > n) begin
                errors++;
                test_done();
            end
        end
    endtask
    function automatic logic [15:0] outs();
        return {7'h00, op_state, rst_n, main_en, can_en, can_lp, can_act,
                lin_lp, lin_act};
    endfunction

    initial begin : main
        int len;
        errors = 0;
        check_count = 0;
        {rst, irq_n, can_uv, wake1, can_sel} = 5'h1F;
        {can_wake, otp_act, otp_rel, wd_pin, wake2, long_sel, wake_pend} = 7'h00;
        wake_en = 3'h1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        wait_rst(SHORT_N + 20, len);
        chk(wd_per, 3'h4);
        chk(wd_mode, 2'b01);
        rd_chk(3'h0, 12'h430);
        wr(3'h0, 12'hFFF);
        chk(rd, 16'h0430);
        settle();
        chk(wd_per, 3'h7);
        chk(wd_mode, 2'b00);
        {wd_pin, wake2} = 2'b11;
        rd_chk(3'h0, 12'hFB8);
        {wd_pin, wake2} = 2'b00;
        rd_chk(3'h0, 12'hF30);
        host_u.xfer(16'h0000, 8, rd);
        rd_chk(3'h0, 12'hF30);
        wr(3'h0, 12'h300);
        for (int a = 2; a < 4; a++) begin
            wr(a[2:0], 12'hA5C ^ a[11:0]);
            wr(3'h4, 12'hFFF);
            rd_chk(a[2:0], 12'hA5C ^ a[11:0]);
        end
        wr(3'h1, 12'hE00);
        settle();
        chk({op_state, can_en, wd_mode}, 16'h000E);
        wr(3'h1, 12'hA00);
        settle();
        chk({op_state, can_en}, 16'h0002);
        // refused sleep: interrupt pending
        {irq_n, wake_en} = 4'h4;
        wr(3'h1, 12'h600);
        settle();
        chk({op_state, rst_n}, 16'h0000);
        wait_rst(SHORT_N + 20, len);
        chk(wd_per, 3'h4);
        rd_chk(3'h1, 12'h200);
        // refused sleep: wake event pending
        {irq_n, wake_en, wake_pend} = 5'h15;
        wr(3'h1, 12'h600);
        settle();
        chk({op_state, rst_n}, 16'h0000);
        wait_rst(SHORT_N + 20, len);
        wake_pend = 1'b0;
        {irq_n, wake_en} = 4'hA;
        wr(3'h1, 12'h600);
        settle();
        chk(outs(), 16'h0108);
        chk(wd_mode, 2'b00);
        long_sel = 1'b1;
        can_wake = 1'b1;
        wait_rst(LONG_N + 40, len);
        can_wake = 1'b0;
        chk(len > LONG_N - 10, 16'h0001);
        settle();
        chk(outs(), 16'h0068);
        rd_chk(3'h1, 12'h200);
        long_sel = 1'b0;
        otp_act = 1'b1;
        settle();
        chk(outs(), 16'h0180);
        chk({hiz, limp}, 16'h0003);
        otp_act = 1'b0;
        repeat (20) @(negedge clock);
        chk(op_state, 2'b11);
        otp_rel = 1'b1;
        wait_rst(SHORT_N + 40, len);
        otp_rel = 1'b0;
        settle();
        chk(outs(), 16'h0068);
        test_done();
    end
endmodule // tb_sbcmc_top

bind sbcmc_top sbcmc_checker #(.SHORT_RST_CYCLES(SHORT_RST_CYCLES)) chk_u (
    .CLOCK(CLOCK), .RST(RST), .SERIAL_SELECT_N(SERIAL_SELECT_N),
    .CAN_WAKE(CAN_WAKE), .OTP_ACT(OTP_ACT), .OTP_REL(OTP_REL),
    .CAN_STANDBY_SEL(CAN_STANDBY_SEL), .SERIAL_OUT_OE(SERIAL_OUT_OE),
    .RESET_OUT_N(RESET_OUT_N), .MAIN_REG_EN(MAIN_REG_EN),
    .CAN_REG_EN(CAN_REG_EN), .CAN_XCVR_ACTIVE(CAN_XCVR_ACTIVE),
    .CAN_XCVR_LOWPWR(CAN_XCVR_LOWPWR), .BUS_HIGH_Z(BUS_HIGH_Z),
    .FALLBACK_DRIVE_OE(FALLBACK_DRIVE_OE), .WDOG_MODE(WDOG_MODE),
    .WDOG_PERIOD_SEL(WDOG_PERIOD_SEL), .OP_MODE_STATE(OP_MODE_STATE));
